/* rtl/config_read_handler.sv */
module config_read_handler #(
   parameter int FIFO_DEPTH = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire cfg_read_pkg::octet_t own_addr,
   input wire cfg_read_pkg::octet_t rx_data,
   input wire logic rx_valid,
   input wire logic rx_end,
   output cfg_read_pkg::octet_t tx_data,
   output logic tx_valid,
   output logic tx_last,
   input wire logic tx_ready,
   output logic cfg_req,
   output logic cfg_loop,
   output logic cfg_ext,
   output cfg_read_pkg::octet_t cfg_tag,
   input wire logic cfg_ack,
   input wire logic cfg_fault,
   input wire logic [31:0] cfg_value,
   output logic busy
);
   import cfg_read_pkg::*;

   generate
      if (FIFO_DEPTH < 2) begin : g_bad_fifo
         $error("config_read_handler needs a FIFO of at least two words");
      end
   endgenerate

   // ==========================================
   // Storage and state
   octet_t frame_mem [MAX_FRAME];
   logic [31:0] value_mem [MAX_SUBS];
   logic [8:0] rx_len_reg;
   logic rx_ovf_reg;
   state_t state_reg;
   logic exc_reg;
   octet_t exc_code_reg;
   logic [7:0] ptr_reg;
   logic [5:0] sub_cnt_reg;
   logic [5:0] emit_idx_reg;
   logic [2:0] k_reg;
   octet_t rsp_bc_reg;
   logic [MAX_SUBS-1:0] fmt_reg;
   octet_t sub_bytes_seen_reg;
   word_t rx_crc;
   word_t tx_crc;
   logic rx_take;
   logic push_valid;
   logic push_fire;
   octet_t push_data;
   logic [31:0] cur_val;
   logic k_last;

   byte_stream_if #(.WIDTH(9)) push_if ();
   byte_stream_if #(.WIDTH(9)) pop_if ();

   function automatic octet_t mem_at(input logic [7:0] base, input int off);
      return frame_mem[8'(int'(base) + off)];
   endfunction : mem_at

   function automatic word_t word_at(input logic [7:0] base, input int off);
      return {mem_at(base, off), mem_at(base, off + 1)};
   endfunction : word_at

   // ==========================================
   // Sub-request fields
   octet_t f_ref;
   octet_t f_loop;
   octet_t f_tag;
   word_t f_file;
   word_t f_cnt;
   logic f_float;
   logic loop_ok;

   assign f_ref = mem_at(ptr_reg, SUB_REF);
   assign f_file = word_at(ptr_reg, SUB_FILE);
   assign f_loop = mem_at(ptr_reg, SUB_LOOP); // R9
   assign f_tag = mem_at(ptr_reg, SUB_TAG); // R10
   assign f_cnt = word_at(ptr_reg, SUB_CNT);
   assign f_float = (f_tag <= TAG_ANALOG_MAX); // R12 R13
   assign loop_ok = (f_loop == LOOP1_BASIC) || (f_loop == LOOP2_BASIC)
                    || (f_loop == LOOP1_EXT) || (f_loop == LOOP2_EXT); // R11

   // ==========================================
   // Frame capture
   assign rx_take = (state_reg == ST_RECEIVE) && rx_valid;

   always_ff @(posedge clk) begin
      if (rx_take && !rx_len_reg[8]) begin
         frame_mem[rx_len_reg[7:0]] <= rx_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rx_len_reg <= '0;
         rx_ovf_reg <= 1'b0;
      end else if (state_reg == ST_CHECK) begin
         rx_len_reg <= '0;
         rx_ovf_reg <= 1'b0;
      end else if (rx_take) begin
         if (rx_len_reg[8]) begin
            rx_ovf_reg <= 1'b1;
         end else begin
            rx_len_reg <= rx_len_reg + 9'h001;
         end
      end
   end

   crc16_unit u_rx_crc (
      .clk(clk),
      .arst_n(arst_n),
      .clear(state_reg == ST_CHECK),
      .enable(rx_take && !rx_len_reg[8]),
      .data(rx_data),
      .crc(rx_crc)
   );

   // ==========================================
   // Request check, lookup and response sequencing
   logic frame_ok;
   logic bc_ok;
   logic last_sub;

   assign frame_ok = !rx_ovf_reg && (rx_len_reg >= 9'(MIN_FRAME))
                     && (frame_mem[POS_ADDR] == own_addr) && (rx_crc == CRC_GOOD); // R16
   assign bc_ok = ({1'b0, frame_mem[POS_BC]} == rx_len_reg - 9'(HDR_LEN + CRC_LEN))
                  && (frame_mem[POS_BC] >= REQ_BC_MIN) && (frame_mem[POS_BC] <= REQ_BC_MAX)
                  && (frame_mem[POS_BC] % 8'(SUB_REQ_LEN) == 8'h00); // R5 R14
   assign last_sub = ({1'b0, ptr_reg} + 9'(SUB_REQ_LEN))
                     == ({1'b0, frame_mem[POS_BC]} + 9'(HDR_LEN)); // R14
   assign k_last = (k_reg == (fmt_reg[emit_idx_reg] ? K_LAST_FLOAT : K_LAST_INT));

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_reg <= ST_RECEIVE;
         exc_reg <= 1'b0;
         exc_code_reg <= 8'h00;
         ptr_reg <= 8'h00;
         sub_cnt_reg <= 6'h00;
         emit_idx_reg <= 6'h00;
         k_reg <= 3'h0;
         rsp_bc_reg <= 8'h00;
         fmt_reg <= '0;
         cfg_loop <= 1'b0;
         cfg_ext <= 1'b0;
         cfg_tag <= 8'h00;
      end else begin
         case (state_reg)
            ST_RECEIVE: begin
               if (rx_end) begin
                  state_reg <= ST_CHECK;
               end
            end
            ST_CHECK: begin
               exc_reg <= 1'b0;
               ptr_reg <= 8'(HDR_LEN);
               sub_cnt_reg <= 6'h00;
               emit_idx_reg <= 6'h00;
               k_reg <= 3'h0;
               rsp_bc_reg <= 8'h00;
               if (!frame_ok) begin
                  state_reg <= ST_RECEIVE; // R16
               end else if (frame_mem[POS_FUNC] != FUNC_READ_CFG) begin
                  exc_reg <= 1'b1; // R1
                  exc_code_reg <= EXC_FUNC;
                  state_reg <= ST_HDR_ADDR;
               end else if (!bc_ok) begin
                  exc_reg <= 1'b1; // R17
                  exc_code_reg <= EXC_VALUE;
                  state_reg <= ST_HDR_ADDR;
               end else begin
                  state_reg <= ST_PARSE;
               end
            end
            ST_PARSE: begin
               if (f_ref != REF_TYPE || f_file != PARAM_VALUE_WORD_REG) begin
                  exc_reg <= 1'b1; // R7 R8 R17
                  exc_code_reg <= EXC_ADDR;
                  state_reg <= ST_HDR_ADDR;
               end else if (!loop_ok || f_tag == TAG_NONE) begin
                  exc_reg <= 1'b1; // R11 R17
                  exc_code_reg <= EXC_ADDR;
                  state_reg <= ST_HDR_ADDR;
               end else if (f_cnt != (f_float ? COUNT_FLOAT : COUNT_INT)) begin
                  exc_reg <= 1'b1; // R4 R17
                  exc_code_reg <= EXC_VALUE;
                  state_reg <= ST_HDR_ADDR;
               end else begin
                  fmt_reg[sub_cnt_reg] <= f_float; // R2
                  cfg_loop <= f_loop[LOOP_SEL_BIT]; // R11
                  cfg_ext <= f_loop[EXT_SEL_BIT];
                  cfg_tag <= f_tag; // R10
                  state_reg <= ST_LOOKUP;
               end
            end
            ST_LOOKUP: begin
               if (cfg_ack && cfg_fault) begin
                  exc_reg <= 1'b1; // R17
                  exc_code_reg <= EXC_ADDR;
                  state_reg <= ST_HDR_ADDR;
               end else if (cfg_ack) begin
                  rsp_bc_reg <= rsp_bc_reg + (fmt_reg[sub_cnt_reg] ? RSP_FLOAT_LEN : RSP_INT_LEN);
                  sub_cnt_reg <= sub_cnt_reg + 6'h01;
                  ptr_reg <= ptr_reg + 8'(SUB_REQ_LEN); // R14
                  state_reg <= last_sub ? ST_HDR_ADDR : ST_PARSE;
               end
            end
            ST_HDR_ADDR: begin
               if (push_fire) begin
                  state_reg <= ST_HDR_FUNC;
               end
            end
            ST_HDR_FUNC: begin
               if (push_fire) begin
                  state_reg <= ST_HDR_COUNT;
               end
            end
            ST_HDR_COUNT: begin
               if (push_fire) begin
                  state_reg <= exc_reg ? ST_CRC_LO : ST_SUB;
               end
            end
            ST_SUB: begin
               if (push_fire) begin
                  if (!k_last) begin
                     k_reg <= k_reg + 3'h1;
                  end else begin
                     k_reg <= 3'h0;
                     emit_idx_reg <= emit_idx_reg + 6'h01;
                     if (emit_idx_reg + 6'h01 == sub_cnt_reg) begin
                        state_reg <= ST_CRC_LO;
                     end
                  end
               end
            end
            ST_CRC_LO: begin
               if (push_fire) begin
                  state_reg <= ST_CRC_HI;
               end
            end
            ST_CRC_HI: begin
               if (push_fire) begin
                  state_reg <= ST_RECEIVE;
               end
            end
            default: begin
               state_reg <= ST_RECEIVE;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (state_reg == ST_LOOKUP && cfg_ack && !cfg_fault) begin
         value_mem[sub_cnt_reg] <= cfg_value;
      end
   end

   assign cfg_req = (state_reg == ST_LOOKUP);
   assign busy = (state_reg != ST_RECEIVE);

   // ==========================================
   // Response bytes
   assign cur_val = fmt_reg[emit_idx_reg] ? value_mem[emit_idx_reg]
                                          : {value_mem[emit_idx_reg][15:0], 16'h0000};

   always_comb begin
      push_valid = 1'b1;
      push_data = 8'h00;
      case (state_reg)
         ST_HDR_ADDR: push_data = frame_mem[POS_ADDR]; // R15
         ST_HDR_FUNC: push_data = exc_reg ? (frame_mem[POS_FUNC] | EXC_FLAG) : FUNC_READ_CFG;
         ST_HDR_COUNT: push_data = exc_reg ? exc_code_reg : rsp_bc_reg; // R5
         ST_SUB: begin
            case (k_reg)
               3'h0: push_data = fmt_reg[emit_idx_reg] ? DBC_FLOAT : DBC_INT; // R6
               3'h1: push_data = REF_TYPE; // R7
               3'h2: push_data = cur_val[31:24]; // R3
               3'h3: push_data = cur_val[23:16];
               3'h4: push_data = cur_val[15:8];
               default: push_data = cur_val[7:0];
            endcase
         end
         ST_CRC_LO: push_data = tx_crc[7:0]; // R16
         ST_CRC_HI: push_data = tx_crc[15:8];
         default: push_valid = 1'b0;
      endcase
   end

   assign push_fire = push_valid && push_if.ready;
   assign push_if.valid = push_valid;
   assign push_if.data = {state_reg == ST_CRC_HI, push_data};

   crc16_unit u_tx_crc (
      .clk(clk),
      .arst_n(arst_n),
      .clear(state_reg == ST_CHECK),
      .enable(push_fire && state_reg != ST_CRC_LO && state_reg != ST_CRC_HI),
      .data(push_data),
      .crc(tx_crc)
   );

   stream_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(clk),
      .arst_n(arst_n),
      .wr(push_if.snk),
      .rd(pop_if.src)
   );

   assign tx_valid = pop_if.valid;
   assign tx_data = pop_if.data[7:0];
   assign tx_last = pop_if.data[8];
   assign pop_if.ready = tx_ready;

   // ==========================================
   // Assertions
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         sub_bytes_seen_reg <= 8'h00;
      end else if (state_reg == ST_CHECK) begin
         sub_bytes_seen_reg <= 8'h00;
      end else if (push_fire && state_reg == ST_SUB) begin
         sub_bytes_seen_reg <= sub_bytes_seen_reg + 8'h01;
      end
   end

   property p_addr_echo;
      @(posedge clk) disable iff (!arst_n)
      (push_fire && state_reg == ST_HDR_ADDR) |-> (push_data == own_addr) ##1 (state_reg == ST_HDR_FUNC);
   endproperty
   a_addr_echo: assert property (p_addr_echo) else $error("address echo wrong"); // R15

   property p_func_code;
      @(posedge clk) disable iff (!arst_n)
      (push_fire && state_reg == ST_HDR_FUNC && !exc_reg)
         |-> (frame_mem[POS_FUNC] == FUNC_READ_CFG) && (push_data == FUNC_READ_CFG);
   endproperty
   a_func_code: assert property (p_func_code) else $error("function code wrong"); // R1

   property p_bad_crc;
      @(posedge clk) disable iff (!arst_n)
      (state_reg == ST_CHECK && rx_crc != CRC_GOOD) |=> (state_reg == ST_RECEIVE && !push_valid);
   endproperty
   a_bad_crc: assert property (p_bad_crc) else $error("bad frame not dropped"); // R16

   property p_dbc;
      @(posedge clk) disable iff (!arst_n)
      (push_fire && state_reg == ST_SUB && k_reg == 3'h0)
         |-> (push_data == (fmt_reg[emit_idx_reg] ? DBC_FLOAT : DBC_INT));
   endproperty
   a_dbc: assert property (p_dbc) else $error("data byte count wrong"); // R6

   property p_ref;
      @(posedge clk) disable iff (!arst_n)
      (push_fire && state_reg == ST_SUB && k_reg == 3'h0) |=> (push_data == REF_TYPE)[*1];
   endproperty
   a_ref: assert property (p_ref) else $error("reference type wrong"); // R7

   property p_bc_match;
      @(posedge clk) disable iff (!arst_n)
      (push_fire && state_reg == ST_CRC_LO && !exc_reg) |-> (sub_bytes_seen_reg == rsp_bc_reg);
   endproperty
   a_bc_match: assert property (p_bc_match) else $error("byte count mismatch"); // R5

   property p_int_order;
      @(posedge clk) disable iff (!arst_n)
      (push_fire && state_reg == ST_SUB && k_reg == 3'h2 && !fmt_reg[emit_idx_reg])
         |-> (push_data == value_mem[emit_idx_reg][15:8]);
   endproperty
   a_int_order: assert property (p_int_order) else $error("integer byte order wrong"); // R3

   property p_lookup_fields;
      @(posedge clk) disable iff (!arst_n)
      $rose(cfg_req) |-> (cfg_tag != TAG_NONE) && (cfg_tag == f_tag)
                         && (f_file == PARAM_VALUE_WORD_REG) && loop_ok;
   endproperty
   a_lookup_fields: assert property (p_lookup_fields) else $error("bad lookup issued"); // R11

   property p_count_mismatch;
      @(posedge clk) disable iff (!arst_n)
      (state_reg == ST_PARSE && f_ref == REF_TYPE && f_file == PARAM_VALUE_WORD_REG && loop_ok
       && f_tag != TAG_NONE && f_cnt != (f_float ? COUNT_FLOAT : COUNT_INT))
         |=> exc_reg && exc_code_reg == EXC_VALUE && state_reg == ST_HDR_ADDR;
   endproperty
   a_count_mismatch: assert property (p_count_mismatch) else $error("count not refused"); // R4

   c_float_sub: cover property (@(posedge clk) disable iff (!arst_n)
      push_fire && state_reg == ST_SUB && k_reg == K_LAST_FLOAT);
   c_int_sub: cover property (@(posedge clk) disable iff (!arst_n)
      push_fire && state_reg == ST_SUB && k_reg == K_LAST_INT && !fmt_reg[emit_idx_reg]);
   c_exception: cover property (@(posedge clk) disable iff (!arst_n)
      push_fire && state_reg == ST_HDR_COUNT && exc_reg);
   c_discard: cover property (@(posedge clk) disable iff (!arst_n)
      state_reg == ST_CHECK && !frame_ok);

endmodule : config_read_handler

/* rtl/cfg_read_pkg.sv */
// Function
// [R1] Host reads config with function 0x14
// [R2] Values are 32-bit float or 16-bit integer
// [R3] Integers travel high byte first
// [R4] Register count 1 integer, 2 float
// [R5] Byte count equals bytes that follow
// [R6] Sub-response count covers type and value
// [R7] Reference type byte is always 06
// [R8] File number must be value register 3
// [R9] Register address word selects the parameter
// [R10] Low address byte is the tag number
// [R11] High byte selects loop and database
// [R12] Tags 01 to 7F are float values
// [R13] Tags 80 to FF are integer values
// [R14] Request holds back-to-back seven-byte sub-requests
// [R15] Response echoes address, function, then sub-responses
// [R16] CRC16 ends frames; bad CRC or address dropped
// [R17] Malformed sub-requests get an exception reply
package cfg_read_pkg;

   typedef logic [7:0] octet_t;
   typedef logic [15:0] word_t;

   // ==========================================
   // Parameter structure register numbers
   localparam word_t PARAM_TYPE_CODE_REG = 16'h0001;
   localparam word_t PARAM_ATTRIBUTE_REG = 16'h0002;
   localparam word_t PARAM_VALUE_WORD_REG = 16'h0003;
   localparam word_t VALUE_LOW_WORD_REG = 16'h0004;
   localparam word_t RANGE_MIN_WORD_REG = 16'h0005;
   localparam word_t RANGE_MIN_LOW_WORD_REG = 16'h0006;
   localparam word_t RANGE_MAX_WORD_REG = 16'h0007;
   localparam word_t RANGE_MAX_LOW_WORD_REG = 16'h0008;
   localparam word_t PARAM_LABEL_TEXT_REG = 16'h0009;

   // ==========================================
   // Message codes
   localparam octet_t FUNC_READ_CFG = 8'h14;
   localparam octet_t EXC_FLAG = 8'h80;
   localparam octet_t REF_TYPE = 8'h06;
   localparam word_t COUNT_INT = 16'h0001;
   localparam word_t COUNT_FLOAT = 16'h0002;
   localparam octet_t LOOP1_BASIC = 8'h00;
   localparam octet_t LOOP2_BASIC = 8'h01;
   localparam octet_t LOOP1_EXT = 8'h40;
   localparam octet_t LOOP2_EXT = 8'h41;
   localparam int LOOP_SEL_BIT = 0;
   localparam int EXT_SEL_BIT = 6;
   localparam octet_t TAG_NONE = 8'h00;
   localparam octet_t TAG_ANALOG_MAX = 8'h7F;
   localparam octet_t EXC_FUNC = 8'h01;
   localparam octet_t EXC_ADDR = 8'h02;
   localparam octet_t EXC_VALUE = 8'h03;

   // ==========================================
   // Frame layout
   localparam int POS_ADDR = 0;
   localparam int POS_FUNC = 1;
   localparam int POS_BC = 2;
   localparam int HDR_LEN = 3;
   localparam int CRC_LEN = 2;
   localparam int MIN_FRAME = 4;
   localparam int MAX_FRAME = 256;
   localparam int SUB_REQ_LEN = 7;
   localparam int SUB_REF = 0;
   localparam int SUB_FILE = 1;
   localparam int SUB_LOOP = 3;
   localparam int SUB_TAG = 4;
   localparam int SUB_CNT = 5;
   localparam int MAX_SUBS = 35;
   localparam octet_t REQ_BC_MIN = 8'h07;
   localparam octet_t REQ_BC_MAX = 8'hF5;
   localparam octet_t DBC_FLOAT = 8'h05;
   localparam octet_t DBC_INT = 8'h03;
   localparam octet_t RSP_FLOAT_LEN = 8'h06;
   localparam octet_t RSP_INT_LEN = 8'h04;
   localparam logic [2:0] K_LAST_FLOAT = 3'h5;
   localparam logic [2:0] K_LAST_INT = 3'h3;

   // ==========================================
   // CRC
   localparam word_t CRC_INIT = 16'hFFFF;
   localparam word_t CRC_POLY = 16'hA001;
   localparam word_t CRC_GOOD = 16'h0000;

   typedef enum logic [3:0] {
      ST_RECEIVE,
      ST_CHECK,
      ST_PARSE,
      ST_LOOKUP,
      ST_HDR_ADDR,
      ST_HDR_FUNC,
      ST_HDR_COUNT,
      ST_SUB,
      ST_CRC_LO,
      ST_CRC_HI
   } state_t;

endpackage : cfg_read_pkg

/* rtl/byte_stream_if.sv */
interface byte_stream_if #(parameter int WIDTH = 9);
   logic [WIDTH-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : byte_stream_if

/* rtl/crc16_unit.sv */
module crc16_unit (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic clear,
   input wire logic enable,
   input wire cfg_read_pkg::octet_t data,
   output cfg_read_pkg::word_t crc
);
   import cfg_read_pkg::*;

   function automatic word_t crc_step(input word_t c, input octet_t d);
      word_t r;
      r = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_step

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         crc <= CRC_INIT;
      end else if (clear) begin
         crc <= CRC_INIT;
      end else if (enable) begin
         crc <= crc_step(crc, data);
      end
   end
endmodule : crc16_unit

/* rtl/stream_fifo.sv */
module stream_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic arst_n,
   byte_stream_if.snk wr,
   byte_stream_if.src rd
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("stream_fifo depth must be a power of two");
      end
   endgenerate

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic full;
   logic empty;

   assign empty = (wr_ptr_reg == rd_ptr_reg);
   assign full = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) && (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data = mem[rd_ptr_reg[AW-1:0]];

   always_ff @(posedge clk) begin
      if (wr.valid && !full) begin
         mem[wr_ptr_reg[AW-1:0]] <= wr.data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         if (wr.valid && !full) begin
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         end
         if (rd.ready && !empty) begin
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         end
      end
   end
endmodule : stream_fifo

/* tb/cfg_db_model.sv */
module cfg_db_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic cfg_req,
   input wire logic cfg_loop,
   input wire logic cfg_ext,
   input wire cfg_read_pkg::octet_t cfg_tag,
   output logic cfg_ack,
   output logic cfg_fault,
   output logic [31:0] cfg_value
);
   timeunit 1ns;
   timeprecision 1ns;
   import cfg_read_pkg::*;
   logic [1:0] wait_cnt;
   logic slow;
   // ==========================================
   // Lookup answer, fast and slow in turn
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cfg_ack <= 1'b0;
         wait_cnt <= 2'h0;
         slow <= 1'b0;
      end else if (cfg_req && !cfg_ack) begin
         wait_cnt <= wait_cnt + 2'h1;
         if (wait_cnt == {slow, 1'b0}) begin
            cfg_ack <= 1'b1;
            wait_cnt <= 2'h0;
            slow <= !slow;
         end
      end else begin
         cfg_ack <= 1'b0;
      end
   end
   assign cfg_fault = cfg_ack && (cfg_tag == 8'hFE);
   assign cfg_value = cfg_ack ? {cfg_tag, ~cfg_tag, 6'h00, cfg_ext, cfg_loop, cfg_tag ^ 8'h5A}
      : {~cfg_tag, cfg_tag, 16'hC33C};
endmodule : cfg_db_model

/* tb/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   import cfg_read_pkg::*;
   logic clk, arst_n, rx_valid, rx_end, tx_valid, tx_last, tx_ready;
   logic cfg_req, cfg_loop, cfg_ext, cfg_ack, cfg_fault, busy;
   octet_t own_addr, rx_data, tx_data, cfg_tag;
   logic [31:0] cfg_value;
   int error_cnt = 0;
   int checks_done = 0;
   octet_t rq[$];
   octet_t eq[$];
   octet_t xt[6][6] = '{'{8'h07, 8'h03, 8'h00, 8'h01, 8'h02, 8'h02},
      '{8'h06, 8'h04, 8'h00, 8'h01, 8'h02, 8'h02}, '{8'h06, 8'h03, 8'h02, 8'h01, 8'h02, 8'h02},
      '{8'h06, 8'h03, 8'h00, 8'hFE, 8'h01, 8'h02}, '{8'h06, 8'h03, 8'h00, 8'h80, 8'h02, 8'h03},
      '{8'h06, 8'h03, 8'h00, 8'h00, 8'h02, 8'h02}};

   config_read_handler i_dut (.clk(clk), .arst_n(arst_n), .own_addr(own_addr),
      .rx_data(rx_data), .rx_valid(rx_valid), .rx_end(rx_end), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready), .cfg_req(cfg_req),
      .cfg_loop(cfg_loop), .cfg_ext(cfg_ext), .cfg_tag(cfg_tag), .cfg_ack(cfg_ack),
      .cfg_fault(cfg_fault), .cfg_value(cfg_value), .busy(busy));
   cfg_db_model i_db (.clk(clk), .arst_n(arst_n), .cfg_req(cfg_req), .cfg_loop(cfg_loop),
      .cfg_ext(cfg_ext), .cfg_tag(cfg_tag), .cfg_ack(cfg_ack), .cfg_fault(cfg_fault),
      .cfg_value(cfg_value));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // ==========================================
   // Helpers
   function automatic word_t crc16(octet_t q[$]);
      word_t c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int b = 0; b < 8; b++) begin
            c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
         end
      end
      return c;
   endfunction : crc16

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic add_sub(input octet_t rt, input octet_t fl, input octet_t hb,
      input octet_t tag, input octet_t cnt);
      octet_t lo;
      lo = {6'h00, hb[6], hb[0]};
      rq = {rq, rt, 8'h00, fl, hb, tag, 8'h00, cnt};
      if (tag[7]) eq = {eq, 8'h03, 8'h06, lo, tag ^ 8'h5A};
      else eq = {eq, 8'h05, 8'h06, tag, ~tag, lo, tag ^ 8'h5A};
   endtask : add_sub

   task automatic run(input octet_t addr, input octet_t fn, input octet_t exc, input bit bad,
      input int stall);
      octet_t f[$];
      octet_t e[$];
      word_t c;
      int n;
      f = {addr, fn, 8'(rq.size()), rq};
      c = crc16(f) ^ {15'h0000, bad};
      f = {f, c[7:0], c[15:8]};
      if (exc != 8'h00) e = {8'h02, fn | 8'h80, exc};
      else e = {8'h02, fn, 8'(eq.size()), eq};
      c = crc16(e);
      if (addr != 8'h02 || bad) e = {};
      else e = {e, c[7:0], c[15:8]};
      foreach (f[i]) begin
         @(negedge clk);
         rx_data = f[i];
         rx_valid = 1'b1;
      end
      @(negedge clk);
      rx_valid = 1'b0;
      rx_end = 1'b1;
      @(negedge clk);
      rx_end = 1'b0;
      repeat (stall) @(negedge clk);
      if (stall > 0) chk({7'h00, busy}, 8'h01);
      n = 0;
      for (int t = 0; t < 400 && n < e.size(); t++) begin
         @(negedge clk);
         tx_ready = (t % 3) != 2;
         if (tx_valid === 1'b1 && tx_ready) begin
            chk(tx_data, e[n]);
            chk({7'h00, tx_last}, {7'h00, n == e.size() - 1});
            n++;
         end
      end
      @(negedge clk);
      tx_ready = 1'b0;
      repeat (40) @(negedge clk);
      chk(8'(n), 8'(e.size()));
      chk({6'h00, tx_valid, busy}, 8'h00);
      $display("test done: function %h, %0d bytes", fn, n);
      rq = {};
      eq = {};
   endtask : run

   task automatic complete_run();
      $display("checks %0d, mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : complete_run

   // ==========================================
   // Tests
   initial begin
      arst_n = 1'b0;
      rx_valid = 1'b0;
      rx_end = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
      own_addr = 8'h02;
      repeat (5) @(negedge clk);
      arst_n = 1'b1;
      add_sub(8'h06, 8'h03, 8'h00, 8'h01, 8'h02);
      run(8'h02, 8'h14, 8'h00, 1'b0, 0);
      add_sub(8'h06, 8'h03, 8'h01, 8'h80, 8'h01);
      add_sub(8'h06, 8'h03, 8'h40, 8'h27, 8'h02);
      add_sub(8'h06, 8'h03, 8'h41, 8'hFF, 8'h01);
      run(8'h02, 8'h14, 8'h00, 1'b0, 60);
      add_sub(8'h06, 8'h03, 8'h00, 8'h01, 8'h02);
      run(8'h02, 8'h03, 8'h01, 1'b0, 0);
      foreach (xt[i]) begin
         add_sub(xt[i][0], xt[i][1], xt[i][2], xt[i][3], xt[i][4]);
         run(8'h02, 8'h14, xt[i][5], 1'b0, 0);
      end
      add_sub(8'h06, 8'h03, 8'h00, 8'h01, 8'h02);
      run(8'h03, 8'h14, 8'h00, 1'b0, 0);
      add_sub(8'h06, 8'h03, 8'h00, 8'h01, 8'h02);
      run(8'h02, 8'h14, 8'h00, 1'b1, 0);
      complete_run();
   end

   initial begin
      #500000;
      error_cnt++;
      complete_run();
   end
endmodule : tb_top
